// ### common/dpm_consts.svh
`ifndef DPM_CONSTS_SVH
`define DPM_CONSTS_SVH

// pad count and pad slots
`define DPM_NPADS 6
`define DPM_PAD_IDX 0
`define DPM_PAD_HOME 1
`define DPM_PAD_CLK 2
`define DPM_PAD_MOSI 3
`define DPM_PAD_MISO 4
`define DPM_PAD_SEL 5

// port e function lanes (1 = general-purpose)
`define DPM_EGP_W 4
`define DPM_EL_CLK 0
`define DPM_EL_MOSI 1
`define DPM_EL_MISO 2
`define DPM_EL_SEL 3
`define DPM_EGP_RST 4'h0

// pull-up register layout
`define DPM_PUR_W 8
`define DPM_PUR_RST 8'hFF
`define DPM_PURC_IDX_BIT 6
`define DPM_PURC_HOME_BIT 7
`define DPM_PURE_CLK_BIT 4
`define DPM_PURE_MOSI_BIT 5
`define DPM_PURE_MISO_BIT 6
`define DPM_PURE_SEL_BIT 7

// pad-side reset levels
`define DPM_PAD_ZERO 6'h00
`define DPM_PAD_ONES 6'h3F
`define DPM_TMR_ZERO 2'h0

`endif

// ### common/dpm_pkg.sv
`include "dpm_consts.svh"

package dpm_pkg;

  // function of a port c pad
  typedef enum logic [1:0] {
    DPM_CFN_DECODER,
    DPM_CFN_TIMER,
    DPM_CFN_GPIO
  } dpm_cfn_t;

  // whole state of the pin mux
  typedef struct packed {
    dpm_cfn_t idx_fn;
    dpm_cfn_t home_fn;
    logic [`DPM_EGP_W-1:0] e_gpio;
    logic [`DPM_PUR_W-1:0] pur_c;
    logic [`DPM_PUR_W-1:0] pur_e;
    logic [`DPM_NPADS-1:0] pad_out;
    logic [`DPM_NPADS-1:0] pad_oe;
    logic [`DPM_NPADS-1:0] pad_pu;
    logic [`DPM_NPADS-1:0] gpio_in;
    logic dec_idx;
    logic dec_home;
    logic [1:0] tmr_in;
    logic spi_clk;
    logic spi_mosi;
    logic spi_miso;
    logic spi_sel_n;
  } dpm_state_t;

  localparam dpm_state_t DPM_ST_RST = '{
    idx_fn: DPM_CFN_DECODER,
    home_fn: DPM_CFN_DECODER,
    e_gpio: `DPM_EGP_RST,
    pur_c: `DPM_PUR_RST,
    pur_e: `DPM_PUR_RST,
    pad_out: `DPM_PAD_ZERO,
    pad_oe: `DPM_PAD_ZERO,
    pad_pu: `DPM_PAD_ONES,
    gpio_in: `DPM_PAD_ONES,
    dec_idx: 1'b1,
    dec_home: 1'b1,
    tmr_in: `DPM_TMR_ZERO,
    spi_clk: 1'b0,
    spi_mosi: 1'b0,
    spi_miso: 1'b0,
    spi_sel_n: 1'b1
  };

endpackage

// ### design/dpm_pad_sync.sv
`timescale 1ns/1ns
`default_nettype none

module dpm_pad_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dpm_sync_st_t;

  dpm_sync_st_t st_reg;
  dpm_sync_st_t st_next;

  // two-stage shift, first stage read only by second
  always_comb begin
    st_next = st_reg;
    st_next.meta = async_i;
    st_next.sync = st_reg.meta;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.sync;

endmodule

`default_nettype wire

// ### design/dpm_pin_mux.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpm_consts.svh"

// Function
// - index pad defaults to decoder index
// - home pad defaults to decoder home
// - spi clock pad defaults to spi
// - master-out pad defaults to spi
// - master-in pad defaults to spi
// - port c bit 6 gates index pull-up
// - port c bit 7 gates home pull-up
// - port e bit 4 gates clock pull-up
// - port e bit 5 gates master-out pull-up
// - port e bit 6 gates master-in pull-up
// - port e bit 7 gates select pull-up
// - each gpio pad has own direction
// - clock pad output as master, input slave
// - master-out pad output master, input slave
// - master data leads sampling edge half period
// - master-in pad input master, output slave
// - unselected slave floats master-in pad
// - slave data leads sampling edge half period
// - select input addresses port in slave
module dpm_pin_mux import dpm_pkg::*; (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic mux_wr_i,
  input wire logic [1:0] idx_fn_i,
  input wire logic [1:0] home_fn_i,
  input wire logic [`DPM_EGP_W-1:0] porte_gpio_sel_i,
  input wire logic portc_pur_wr_i,
  input wire logic [`DPM_PUR_W-1:0] portc_pur_i,
  input wire logic porte_pur_wr_i,
  input wire logic [`DPM_PUR_W-1:0] porte_pur_i,
  output logic [`DPM_PUR_W-1:0] portc_pullup_enables_o,
  output logic [`DPM_PUR_W-1:0] porte_pullup_enables_o,
  input wire logic [`DPM_NPADS-1:0] gpio_dir_i,
  input wire logic [`DPM_NPADS-1:0] gpio_out_i,
  output logic [`DPM_NPADS-1:0] gpio_in_o,
  input wire logic timer_a_ch2_out_i,
  input wire logic timer_a_ch2_oe_i,
  output logic timer_a_ch2_in_o,
  input wire logic timer_a_ch3_out_i,
  input wire logic timer_a_ch3_oe_i,
  output logic timer_a_ch3_in_o,
  output logic dec0_index_in_o,
  output logic dec0_home_in_o,
  input wire logic spi_master_i,
  input wire logic spi_p0_clk_out_i,
  input wire logic spi_p0_master_out_i,
  input wire logic spi_p0_slave_out_i,
  output logic spi_p0_clk_in_o,
  output logic spi_p0_master_out_in_o,
  output logic spi_p0_master_in_o,
  output logic spi_p0_select_n_o,
  input wire logic [`DPM_NPADS-1:0] pad_in_i,
  output logic [`DPM_NPADS-1:0] pad_out_o,
  output logic [`DPM_NPADS-1:0] pad_oe_o,
  output logic [`DPM_NPADS-1:0] pad_pullup_o
);

  dpm_state_t st_reg;
  dpm_state_t st_next;
  logic [`DPM_NPADS-1:0] pad_sync;

  // port c pad drive: returns {oe, out}
  function automatic logic [1:0] cfn_drive(
    input dpm_cfn_t fn,
    input logic tmr_out,
    input logic tmr_oe,
    input logic gp_out,
    input logic gp_dir
  );
    logic [1:0] r;
    r = 2'h0;
    case (fn)
      DPM_CFN_TIMER: r = {tmr_oe, tmr_out};
      DPM_CFN_GPIO: r = {gp_dir, gp_out};
      default: r = 2'h0;
    endcase
    return r;
  endfunction

  // port e pad drive: returns {oe, out}
  function automatic logic [1:0] efn_drive(
    input logic gp_sel,
    input logic spi_oe,
    input logic spi_out,
    input logic gp_out,
    input logic gp_dir
  );
    return gp_sel ? {gp_dir, gp_out} : {spi_oe, spi_out};
  endfunction

  // legal port c function code
  function automatic logic cfn_ok(input logic [1:0] code);
    return code <= DPM_CFN_GPIO;
  endfunction

  // pad inputs cross into the clock domain
  dpm_pad_sync #(
    .W(`DPM_NPADS),
    .RST_VAL(`DPM_PAD_ONES)
  ) u_pad_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(pad_in_i),
    .sync_o(pad_sync)
  );

  // next state
  always_comb begin
    logic slave_sel;
    st_next = st_reg;
    slave_sel = 1'b0;
    // function selects; reset leaves decoder and spi in place
    if (mux_wr_i) begin
      if (cfn_ok(idx_fn_i)) begin
        st_next.idx_fn = dpm_cfn_t'(idx_fn_i);
      end
      if (cfn_ok(home_fn_i)) begin
        st_next.home_fn = dpm_cfn_t'(home_fn_i);
      end
      st_next.e_gpio = porte_gpio_sel_i;
    end
    if (portc_pur_wr_i) begin
      st_next.pur_c = portc_pur_i;
    end
    if (porte_pur_wr_i) begin
      st_next.pur_e = porte_pur_i;
    end
    // port c pad drivers
    {st_next.pad_oe[`DPM_PAD_IDX], st_next.pad_out[`DPM_PAD_IDX]} =
      cfn_drive(st_reg.idx_fn, timer_a_ch2_out_i, timer_a_ch2_oe_i,
        gpio_out_i[`DPM_PAD_IDX], gpio_dir_i[`DPM_PAD_IDX]);
    {st_next.pad_oe[`DPM_PAD_HOME], st_next.pad_out[`DPM_PAD_HOME]} =
      cfn_drive(st_reg.home_fn, timer_a_ch3_out_i, timer_a_ch3_oe_i,
        gpio_out_i[`DPM_PAD_HOME], gpio_dir_i[`DPM_PAD_HOME]);
    // spi pads; all share one output flop stage, so skew is kept
    {st_next.pad_oe[`DPM_PAD_CLK], st_next.pad_out[`DPM_PAD_CLK]} =
      efn_drive(st_reg.e_gpio[`DPM_EL_CLK], spi_master_i,
        spi_p0_clk_out_i, gpio_out_i[`DPM_PAD_CLK],
        gpio_dir_i[`DPM_PAD_CLK]);
    {st_next.pad_oe[`DPM_PAD_MOSI], st_next.pad_out[`DPM_PAD_MOSI]} =
      efn_drive(st_reg.e_gpio[`DPM_EL_MOSI], spi_master_i,
        spi_p0_master_out_i, gpio_out_i[`DPM_PAD_MOSI],
        gpio_dir_i[`DPM_PAD_MOSI]);
    // slave drives master-in only while selected
    slave_sel = !st_reg.e_gpio[`DPM_EL_SEL] && !pad_sync[`DPM_PAD_SEL];
    {st_next.pad_oe[`DPM_PAD_MISO], st_next.pad_out[`DPM_PAD_MISO]} =
      efn_drive(st_reg.e_gpio[`DPM_EL_MISO], !spi_master_i && slave_sel,
        spi_p0_slave_out_i, gpio_out_i[`DPM_PAD_MISO],
        gpio_dir_i[`DPM_PAD_MISO]);
    {st_next.pad_oe[`DPM_PAD_SEL], st_next.pad_out[`DPM_PAD_SEL]} =
      efn_drive(st_reg.e_gpio[`DPM_EL_SEL], 1'b0, 1'b0,
        gpio_out_i[`DPM_PAD_SEL], gpio_dir_i[`DPM_PAD_SEL]);
    // pull-ups follow their register bits
    st_next.pad_pu[`DPM_PAD_IDX] = st_reg.pur_c[`DPM_PURC_IDX_BIT];
    st_next.pad_pu[`DPM_PAD_HOME] = st_reg.pur_c[`DPM_PURC_HOME_BIT];
    st_next.pad_pu[`DPM_PAD_CLK] = st_reg.pur_e[`DPM_PURE_CLK_BIT];
    st_next.pad_pu[`DPM_PAD_MOSI] = st_reg.pur_e[`DPM_PURE_MOSI_BIT];
    st_next.pad_pu[`DPM_PAD_MISO] = st_reg.pur_e[`DPM_PURE_MISO_BIT];
    st_next.pad_pu[`DPM_PAD_SEL] = st_reg.pur_e[`DPM_PURE_SEL_BIT];
    // inbound levels to the peripherals, idle when not selected, except gpio_in which always follows the pads
    st_next.gpio_in = pad_sync;
    st_next.dec_idx = (st_reg.idx_fn == DPM_CFN_DECODER) ?
      pad_sync[`DPM_PAD_IDX] : 1'b1;
    st_next.dec_home = (st_reg.home_fn == DPM_CFN_DECODER) ?
      pad_sync[`DPM_PAD_HOME] : 1'b1;
    st_next.tmr_in[0] = (st_reg.idx_fn == DPM_CFN_TIMER) &&
      pad_sync[`DPM_PAD_IDX];
    st_next.tmr_in[1] = (st_reg.home_fn == DPM_CFN_TIMER) &&
      pad_sync[`DPM_PAD_HOME];
    st_next.spi_clk = !st_reg.e_gpio[`DPM_EL_CLK] &&
      pad_sync[`DPM_PAD_CLK];
    st_next.spi_mosi = !st_reg.e_gpio[`DPM_EL_MOSI] &&
      pad_sync[`DPM_PAD_MOSI];
    st_next.spi_miso = !st_reg.e_gpio[`DPM_EL_MISO] &&
      pad_sync[`DPM_PAD_MISO];
    st_next.spi_sel_n = st_reg.e_gpio[`DPM_EL_SEL] ||
      pad_sync[`DPM_PAD_SEL];
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg <= DPM_ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign portc_pullup_enables_o = st_reg.pur_c;
  assign porte_pullup_enables_o = st_reg.pur_e;
  assign gpio_in_o = st_reg.gpio_in;
  assign timer_a_ch2_in_o = st_reg.tmr_in[0];
  assign timer_a_ch3_in_o = st_reg.tmr_in[1];
  assign dec0_index_in_o = st_reg.dec_idx;
  assign dec0_home_in_o = st_reg.dec_home;
  assign spi_p0_clk_in_o = st_reg.spi_clk;
  assign spi_p0_master_out_in_o = st_reg.spi_mosi;
  assign spi_p0_master_in_o = st_reg.spi_miso;
  assign spi_p0_select_n_o = st_reg.spi_sel_n;
  assign pad_out_o = st_reg.pad_out;
  assign pad_oe_o = st_reg.pad_oe;
  assign pad_pullup_o = st_reg.pad_pu;

  // checks
  default clocking dpm_cb @(posedge clk_i);
  endclocking

  chk_idx_default: assert property (
    sys_rst_i ##1 !sys_rst_i && !mux_wr_i |=>
      dec0_index_in_o == $past(pad_sync[`DPM_PAD_IDX])
  ) else $error("index pad not on decoder after reset");

  chk_home_default: assert property (
    sys_rst_i ##1 !sys_rst_i && !mux_wr_i |=>
      dec0_home_in_o == $past(pad_sync[`DPM_PAD_HOME])
  ) else $error("home pad not on decoder after reset");

  chk_spi_default: assert property (
    sys_rst_i ##1 !sys_rst_i && !mux_wr_i |=>
      pad_oe_o[`DPM_PAD_CLK] == $past(spi_master_i)
  ) else $error("clock pad not on spi after reset");

  chk_mosi_default: assert property (
    sys_rst_i ##1 !sys_rst_i && !mux_wr_i |=>
      pad_out_o[`DPM_PAD_MOSI] == $past(spi_p0_master_out_i)
  ) else $error("master-out pad not on spi after reset");

  chk_miso_default: assert property (
    sys_rst_i ##1 !sys_rst_i && !mux_wr_i |=>
      spi_p0_master_in_o == $past(pad_sync[`DPM_PAD_MISO])
  ) else $error("master-in pad not on spi after reset");

  chk_pullup_c: assert property (disable iff (sys_rst_i)
    portc_pur_wr_i ##1 1'b1 |=>
      pad_pullup_o[`DPM_PAD_IDX] == $past(portc_pur_i[`DPM_PURC_IDX_BIT], 2)
      && pad_pullup_o[`DPM_PAD_HOME] ==
      $past(portc_pur_i[`DPM_PURC_HOME_BIT], 2)
  ) else $error("port c pull-up not following register");

  chk_pullup_e: assert property (disable iff (sys_rst_i)
    pad_pullup_o == {st_reg.pur_e[`DPM_PURE_SEL_BIT],
      st_reg.pur_e[`DPM_PURE_MISO_BIT], st_reg.pur_e[`DPM_PURE_MOSI_BIT],
      st_reg.pur_e[`DPM_PURE_CLK_BIT], st_reg.pur_c[`DPM_PURC_HOME_BIT],
      st_reg.pur_c[`DPM_PURC_IDX_BIT]} || $changed(st_reg.pur_e) ||
      $changed(st_reg.pur_c) || $past(sys_rst_i)
  ) else $error("pull-ups off their register bits");

  chk_gpio_dir: assert property (disable iff (sys_rst_i)
    st_reg.e_gpio[`DPM_EL_MOSI] && !mux_wr_i |=>
      pad_oe_o[`DPM_PAD_MOSI] == $past(gpio_dir_i[`DPM_PAD_MOSI])
  ) else $error("gpio direction not applied");

  chk_clk_role: assert property (disable iff (sys_rst_i)
    !st_reg.e_gpio[`DPM_EL_CLK] && !mux_wr_i |=>
      pad_oe_o[`DPM_PAD_CLK] == $past(spi_master_i)
  ) else $error("clock pad direction wrong for role");

  chk_mosi_role: assert property (disable iff (sys_rst_i)
    !st_reg.e_gpio[`DPM_EL_MOSI] && spi_master_i |=>
      pad_oe_o[`DPM_PAD_MOSI] &&
      pad_out_o[`DPM_PAD_MOSI] == $past(spi_p0_master_out_i)
  ) else $error("master-out pad direction wrong");

  chk_miso_float: assert property (disable iff (sys_rst_i)
    !st_reg.e_gpio[`DPM_EL_MISO] &&
      (spi_master_i || pad_sync[`DPM_PAD_SEL]) && !mux_wr_i |=>
      !pad_oe_o[`DPM_PAD_MISO]
  ) else $error("master-in driven while not a selected slave");

  chk_miso_drive: assert property (disable iff (sys_rst_i)
    !st_reg.e_gpio[`DPM_EL_MISO] && !st_reg.e_gpio[`DPM_EL_SEL] &&
      !spi_master_i && !pad_sync[`DPM_PAD_SEL] && !mux_wr_i |=>
      pad_oe_o[`DPM_PAD_MISO] &&
      pad_out_o[`DPM_PAD_MISO] == $past(spi_p0_slave_out_i)
  ) else $error("selected slave not driving master-in");

  chk_select_path: assert property (disable iff (sys_rst_i)
    !st_reg.e_gpio[`DPM_EL_SEL] && !mux_wr_i |=>
      spi_p0_select_n_o == $past(pad_sync[`DPM_PAD_SEL])
  ) else $error("select pad not passed to spi");

  cov_slave_sel: cover property (disable iff (sys_rst_i)
    !spi_master_i ##1 pad_oe_o[`DPM_PAD_MISO]);
  cov_master: cover property (disable iff (sys_rst_i)
    pad_oe_o[`DPM_PAD_CLK] && pad_oe_o[`DPM_PAD_MOSI]);
  cov_timer_fn: cover property (disable iff (sys_rst_i)
    st_reg.idx_fn == DPM_CFN_TIMER && timer_a_ch2_oe_i);
  cov_pullup_off: cover property (disable iff (sys_rst_i)
    !pad_pullup_o[`DPM_PAD_SEL]);

endmodule

`default_nettype wire

// ### dv/dpm_peer_model.sv
`timescale 1ns/1ns
`default_nettype none

module dpm_peer_model (
  input wire logic clk_i,
  input wire logic [5:0] pad_out_i,
  input wire logic [5:0] pad_oe_i,
  input wire logic [5:0] pad_pu_i,
  input wire logic [5:0] drv_en_i,
  input wire logic [5:0] drv_val_i,
  input wire logic sel_n_i,
  output logic [5:0] pad_lvl_o
);
  logic [5:0] drv;
  logic [5:0] float_reg = 6'h15;

  // peer data moves on falling edge, half a period before sampling
  always_comb begin
    drv = drv_en_i & ~pad_oe_i;
    if (pad_oe_i[2] && sel_n_i) begin
      drv[4] = 1'b0;
    end
  end

  // undriven pad without pull-up wanders every cycle
  always @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end

  // wire level: device, then peer, then pull-up or wander
  assign pad_lvl_o = (pad_oe_i & pad_out_i) | (drv & drv_val_i)
    | (~pad_oe_i & ~drv & (pad_pu_i | float_reg));
endmodule

`default_nettype wire

// ### dv/dpm_pin_mux_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dpm_consts.svh"

module dpm_pin_mux_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic mux_wr, pc_wr, pe_wr, role, t2o, t2e, t3o, t3e, sclk, smo, sso;
  logic psel_n, t2i, t3i, dxi, dhi, sci, smi, sfi, ssn;
  logic [1:0] ifn, hfn, e_ifn, e_hfn;
  logic [3:0] egp, e_egp;
  logic [7:0] pc_d, pe_d, e_purc, e_pure, rb_c, rb_e;
  logic [5:0] gdir, gout, poe, pval, lvl, p_out, p_oe, p_pu, g_in;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  dpm_pin_mux dpm_pin_mux_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .mux_wr_i(mux_wr), .idx_fn_i(ifn), .home_fn_i(hfn),
    .porte_gpio_sel_i(egp), .portc_pur_wr_i(pc_wr), .portc_pur_i(pc_d),
    .porte_pur_wr_i(pe_wr), .porte_pur_i(pe_d),
    .portc_pullup_enables_o(rb_c), .porte_pullup_enables_o(rb_e),
    .gpio_dir_i(gdir), .gpio_out_i(gout), .gpio_in_o(g_in),
    .timer_a_ch2_out_i(t2o), .timer_a_ch2_oe_i(t2e), .timer_a_ch2_in_o(t2i),
    .timer_a_ch3_out_i(t3o), .timer_a_ch3_oe_i(t3e), .timer_a_ch3_in_o(t3i),
    .dec0_index_in_o(dxi), .dec0_home_in_o(dhi), .spi_master_i(role),
    .spi_p0_clk_out_i(sclk), .spi_p0_master_out_i(smo),
    .spi_p0_slave_out_i(sso), .spi_p0_clk_in_o(sci),
    .spi_p0_master_out_in_o(smi), .spi_p0_master_in_o(sfi),
    .spi_p0_select_n_o(ssn), .pad_in_i(lvl), .pad_out_o(p_out),
    .pad_oe_o(p_oe), .pad_pullup_o(p_pu));

  dpm_peer_model dpm_peer_model_inst (.clk_i(clk_i), .pad_out_i(p_out),
    .pad_oe_i(p_oe), .pad_pu_i(p_pu), .drv_en_i(poe), .drv_val_i(pval),
    .sel_n_i(psel_n), .pad_lvl_o(lvl));

  // clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic cmp_vec(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // expected pad and peripheral state from the shadow settings
  task automatic check_all();
    logic [5:0] eoe, eout, pd, def, el, epu;
    logic s5;
    eoe[0] = (e_ifn == 2'h1) ? t2e : (e_ifn == 2'h2) & gdir[0];
    eout[0] = (e_ifn == 2'h1) ? t2o : gout[0];
    eoe[1] = (e_hfn == 2'h1) ? t3e : (e_hfn == 2'h2) & gdir[1];
    eout[1] = (e_hfn == 2'h1) ? t3o : gout[1];
    eoe[2] = e_egp[0] ? gdir[2] : role;
    eout[2] = e_egp[0] ? gout[2] : sclk;
    eoe[3] = e_egp[1] ? gdir[3] : role;
    eout[3] = e_egp[1] ? gout[3] : smo;
    eoe[5] = e_egp[3] & gdir[5];
    eout[5] = gout[5];
    s5 = eoe[5] ? eout[5] : (poe[5] ? pval[5] : 1'b1);
    // a select pad in gpio mode never selects the slave
    eoe[4] = e_egp[2] ? gdir[4] : !role && !e_egp[3] && !s5;
    eout[4] = e_egp[2] ? gout[4] : sso;
    epu = {e_pure[7:4], e_purc[7:6]};
    pd = poe & ~eoe;
    pd[4] = pd[4] & !(eoe[2] && psel_n);
    def = eoe | pd | epu;
    el = (eoe & eout) | (pd & pval) | (~eoe & ~pd);
    cmp_vec({2'h0, p_oe}, {2'h0, eoe}, "oe");
    cmp_vec({2'h0, p_out & eoe}, {2'h0, eout & eoe}, "out");
    cmp_vec({2'h0, p_pu}, {2'h0, epu}, "pu");
    cmp_vec(rb_c, e_purc, "pur c");
    cmp_vec(rb_e, e_pure, "pur e");
    cmp_vec({2'h0, g_in & def}, {2'h0, el & def}, "gpio in");
    cmp_bit(dxi | ~def[0], (e_ifn != 2'h0) | el[0] | ~def[0], "idx");
    cmp_bit(dhi | ~def[1], (e_hfn != 2'h0) | el[1] | ~def[1], "home");
    cmp_bit(t2i & def[0], (e_ifn == 2'h1) & el[0] & def[0], "ta2");
    cmp_bit(t3i & def[1], (e_hfn == 2'h1) & el[1] & def[1], "ta3");
    cmp_bit(sci & def[2], ~e_egp[0] & el[2] & def[2], "clk");
    cmp_bit(smi & def[3], ~e_egp[1] & el[3] & def[3], "mo");
    cmp_bit(sfi & def[4], ~e_egp[2] & el[4] & def[4], "mi");
    cmp_bit(ssn | ~def[5], e_egp[3] | el[5] | ~def[5], "sel");
  endtask

  // drop strobes, let pipelines settle, then check
  // master-in level trails select by two synchroniser passes
  task automatic apply();
    @(negedge clk_i);
    {mux_wr, pc_wr, pe_wr} = 3'h0;
    repeat (7) @(negedge clk_i);
    check_all();
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    {mux_wr, pc_wr, pe_wr, e_ifn, e_hfn} = 7'h00;
    e_egp = `DPM_EGP_RST;
    {e_purc, e_pure} = 16'hFFFF;
    repeat (6) @(negedge clk_i);
    cmp_vec({2'h0, p_oe}, 8'h00, "rst oe");
    cmp_vec({2'h0, p_pu}, 8'h3F, "rst pu");
    sys_rst_i = 1'b0;
    $display("test reset done");
  endtask

  task automatic step(input logic wr);
    @(negedge clk_i);
    {role, t2o, t2e, t3o, t3e, sclk, smo, sso, psel_n} = 9'($urandom);
    {gdir, gout, poe, pval} = 24'($urandom);
    if (wr) begin
      {ifn, hfn, egp, pc_d, pe_d, pc_wr, pe_wr} = 26'($urandom);
      mux_wr = 1'b1;
      e_ifn = (ifn == 2'h3) ? e_ifn : ifn;
      e_hfn = (hfn == 2'h3) ? e_hfn : hfn;
      e_egp = egp;
      e_purc = pc_wr ? pc_d : e_purc;
      e_pure = pe_wr ? pe_d : e_pure;
    end
    poe[5] = poe[5] | ~e_pure[7];
    apply();
  endtask

  // cycle limit
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("MISMATCH %0t timeout", $time);
      end_of_test();
    end
  end

  initial begin
    {mux_wr, pc_wr, pe_wr, role, t2o, t2e, t3o, t3e, sclk, smo, sso} = 11'h0;
    {ifn, hfn, egp, pc_d, pe_d, psel_n} = 25'h0;
    {gdir, gout, poe, pval} = 24'h0;
    void'($urandom(65958));
    do_reset();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      role = i[0];
      psel_n = 1'b0;
      poe = 6'h3F;
      pval = {i[1], 5'($urandom)};
      apply();
    end
    $display("test defaults and roles done");
    for (int j = 0; j < 2; j++) begin
      @(negedge clk_i);
      {pc_wr, pe_wr} = 2'h3;
      pc_d = j[0] ? 8'hAA : 8'h00;
      pe_d = pc_d;
      {e_purc, e_pure} = {pc_d, pe_d};
      apply();
    end
    $display("test pullup corners done");
    for (int k = 0; k < 300; k++) begin
      step(k % 3 == 0);
    end
    $display("test random done");
    do_reset();
    apply();
    $display("test second reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
